// ---- drive_pkg.sv ----
package drive_pkg;

  // clock and restart delay time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS  = 100000;
  localparam int TICK_CYCLES   = (TICK_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // terminals and function codes
  localparam int          NUM_TERMS    = 5;
  localparam int          FN_W         = 5;
  localparam int          FREQ_W       = 16;
  localparam logic [4:0]  FN_MOTOR_SET = 5'h08;
  localparam logic [4:0]  FN_RAMP_TWO  = 5'h09;
  localparam logic [4:0]  FN_COAST     = 5'h0b;
  localparam logic [4:0]  FN_NONE      = 5'h1f;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_ASSIGN   = 8'h04;
  localparam logic [7:0] OFF_POLARITY = 8'h08;
  localparam logic [7:0] OFF_ACCEL1   = 8'h0c;
  localparam logic [7:0] OFF_DECEL1   = 8'h10;
  localparam logic [7:0] OFF_ACCEL2   = 8'h14;
  localparam logic [7:0] OFF_DECEL2   = 8'h18;
  localparam logic [7:0] OFF_TARGET   = 8'h1c;
  localparam logic [7:0] OFF_DELAY    = 8'h20;
  localparam logic [7:0] OFF_STATUS   = 8'h24;
  localparam logic [7:0] OFF_FREQ     = 8'h28;

  // control field positions
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_RESTART_BIT = 1;

  // status field positions
  localparam int STAT_SET_BIT   = 0;
  localparam int STAT_TWO_BIT   = 1;
  localparam int STAT_OE_BIT    = 2;
  localparam int STAT_COAST_BIT = 3;
  localparam int STAT_STATE_LSB = 4;

  // reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [24:0] ASSIGN_RST   = {FN_NONE, FN_NONE, FN_COAST,
                                          FN_RAMP_TWO, FN_MOTOR_SET};
  localparam logic [4:0]  POLARITY_RST = 5'h00;
  localparam logic [15:0] RAMP_RST     = 16'h0100;
  localparam logic [15:0] TARGET_RST   = 16'h0000;
  localparam logic [15:0] DELAY_RST    = 16'h0000;

  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_RUN   = 2'b01,
    ST_COAST = 2'b11,
    ST_WAIT  = 2'b10
  } drive_state_type;

endpackage

// ---- term_sync.sv ----
`timescale 1ns/1ps
module term_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

  sync_delay_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(reset_n, 2) |-> sync_out == $past(async_in, 2))
    else $error("terminal sync latency is not two cycles");

endmodule

// ---- ramp_gen.sv ----
`timescale 1ns/1ps
module ramp_gen #(
  parameter int FREQ_W = 16
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              hold,
  input  wire logic              load,
  input  wire logic [FREQ_W-1:0] load_value,
  input  wire logic [FREQ_W-1:0] target,
  input  wire logic [15:0]       interval_up,
  input  wire logic [15:0]       interval_down,
  output logic      [FREQ_W-1:0] freq
);

  logic [15:0] step_cnt_reg;
  logic        going_up;
  logic [15:0] interval;

  assign going_up = freq < target;
  // rate taken live, so a select change bends a ramp already underway
  assign interval = going_up ? interval_up : interval_down;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      freq         <= '0;
      step_cnt_reg <= 16'h0000;
    end else if (load) begin
      freq         <= load_value;
      step_cnt_reg <= 16'h0000;
    end else if (hold || freq == target) begin
      step_cnt_reg <= 16'h0000;
    end else if (step_cnt_reg >= interval) begin
      step_cnt_reg <= 16'h0000;
      freq         <= going_up ? freq + 1'b1 : freq - 1'b1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  ramp_step_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!load && !hold && going_up && step_cnt_reg >= interval)
    |=> freq == $past(freq) + 1'b1)
    else $error("ramp did not step up after its interval");

  ramp_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!load && hold) |=> $stable(freq))
    else $error("ramp moved while held");

endmodule

// ---- drive_input_function_selector.sv ----
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
module drive_input_function_selector #(
  parameter int TICK_CYCLES = drive_pkg::TICK_CYCLES
) (
  input  wire logic                            core_clk,
  input  wire logic                            reset_n,
  input  wire logic [drive_pkg::NUM_TERMS-1:0] term_in,
  input  wire logic [drive_pkg::FREQ_W-1:0]    motor_speed,
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [7:0]                      wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [31:0]                     wb_dat_i,
  output logic      [31:0]                     wb_dat_o,
  output logic                                 wb_ack_o,
  output logic                                 output_enable,
  output logic                                 motor_set_two,
  output logic                                 ramp_two,
  output logic      [drive_pkg::FREQ_W-1:0]    freq_out
);

  localparam int NT = drive_pkg::NUM_TERMS;
  localparam int FW = drive_pkg::FREQ_W;

  // software registers
  logic [1:0]          ctrl_reg;
  logic [NT*5-1:0]     assign_reg;
  logic [NT-1:0]       polarity_reg;
  logic [15:0]         accel1_reg;
  logic [15:0]         decel1_reg;
  logic [15:0]         accel2_reg;
  logic [15:0]         decel2_reg;
  logic [FW-1:0]       target_reg;
  logic [15:0]         delay_reg;

  // bus path
  logic                req;
  logic                wr_en;
  logic [31:0]         rd_mux;
  logic [31:0]         wr_word;

  // terminal path
  logic [NT-1:0]       term_sync_out;
  logic [NT-1:0]       level;
  logic [NT-1:0]       set_hit;
  logic [NT-1:0]       two_hit;
  logic [NT-1:0]       coast_hit;
  logic                set_level;
  logic                two_level;
  logic                coast_level;

  // sequencing
  drive_pkg::drive_state_type state_reg;
  drive_pkg::drive_state_type state_next;
  logic                run_level;
  logic                restart_sel;
  logic                restart_load;
  logic [FW-1:0]       load_value;
  logic [FW-1:0]       ramp_target;
  logic [FW-1:0]       ramp_freq;
  logic [15:0]         interval_up;
  logic [15:0]         interval_down;
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
  logic [15:0]         delay_cnt_reg;
  logic                delay_done;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0]  sel
  );
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_word & ~mask) | (new_word & mask);
  endfunction

  assign run_level   = ctrl_reg[drive_pkg::CTRL_RUN_BIT];
  assign restart_sel = ctrl_reg[drive_pkg::CTRL_RESTART_BIT];

  // bus: a write lands on the ack edge, while the request still stands
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_word = merge_bytes(rd_mux, wb_dat_i, wb_sel_i);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      drive_pkg::OFF_CTRL:     rd_mux[1:0]      = ctrl_reg;
      drive_pkg::OFF_ASSIGN:   rd_mux[NT*5-1:0] = assign_reg;
      drive_pkg::OFF_POLARITY: rd_mux[NT-1:0]   = polarity_reg;
      drive_pkg::OFF_ACCEL1:   rd_mux[15:0]     = accel1_reg;
      drive_pkg::OFF_DECEL1:   rd_mux[15:0]     = decel1_reg;
      drive_pkg::OFF_ACCEL2:   rd_mux[15:0]     = accel2_reg;
      drive_pkg::OFF_DECEL2:   rd_mux[15:0]     = decel2_reg;
      drive_pkg::OFF_TARGET:   rd_mux[FW-1:0]   = target_reg;
      drive_pkg::OFF_DELAY:    rd_mux[15:0]     = delay_reg;
      drive_pkg::OFF_STATUS: begin
        rd_mux[drive_pkg::STAT_SET_BIT]   = motor_set_two;
        rd_mux[drive_pkg::STAT_TWO_BIT]   = ramp_two;
        rd_mux[drive_pkg::STAT_OE_BIT]    = output_enable;
        rd_mux[drive_pkg::STAT_COAST_BIT] = coast_level;
        rd_mux[drive_pkg::STAT_STATE_LSB +: 2] = state_reg;
      end
      drive_pkg::OFF_FREQ:     rd_mux[FW-1:0]   = freq_out;
      default:                 rd_mux           = 32'h0000_0000;
    endcase
  end

  // unmapped addresses still ack, reading zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_reg     <= drive_pkg::CTRL_RST;
      assign_reg   <= drive_pkg::ASSIGN_RST;
      polarity_reg <= drive_pkg::POLARITY_RST;
      accel1_reg   <= drive_pkg::RAMP_RST;
      decel1_reg   <= drive_pkg::RAMP_RST;
      accel2_reg   <= drive_pkg::RAMP_RST;
      decel2_reg   <= drive_pkg::RAMP_RST;
      target_reg   <= drive_pkg::TARGET_RST;
      delay_reg    <= drive_pkg::DELAY_RST;
    end else if (wr_en) begin
      case (wb_adr_i)
        drive_pkg::OFF_CTRL:     ctrl_reg     <= wr_word[1:0];
        drive_pkg::OFF_ASSIGN:   assign_reg   <= wr_word[NT*5-1:0];
        drive_pkg::OFF_POLARITY: polarity_reg <= wr_word[NT-1:0];
        drive_pkg::OFF_ACCEL1:   accel1_reg   <= wr_word[15:0];
        drive_pkg::OFF_DECEL1:   decel1_reg   <= wr_word[15:0];
        drive_pkg::OFF_ACCEL2:   accel2_reg   <= wr_word[15:0];
        drive_pkg::OFF_DECEL2:   decel2_reg   <= wr_word[15:0];
        drive_pkg::OFF_TARGET:   target_reg   <= wr_word[FW-1:0];
        drive_pkg::OFF_DELAY:    delay_reg    <= wr_word[15:0];
        default: begin
        end
      endcase
    end
  end

  // terminals
  term_sync #(
    .WIDTH    (NT)
  ) u_term_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (term_in),
    .sync_out (term_sync_out)
  );

  for (genvar g = 0; g < NT; g++) begin : term_map
    logic [4:0] fn;
    assign fn = assign_reg[g*5 +: 5];
    assign level[g]     = term_sync_out[g] ^ polarity_reg[g];
    assign set_hit[g]   = level[g] && (fn == drive_pkg::FN_MOTOR_SET);
    assign two_hit[g]   = level[g] && (fn == drive_pkg::FN_RAMP_TWO);
    assign coast_hit[g] = level[g] && (fn == drive_pkg::FN_COAST);
  end

  assign set_level   = |set_hit;
  assign two_level   = |two_hit;
  assign coast_level = |coast_hit;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      motor_set_two <= 1'b0;
    end else if (state_reg == drive_pkg::ST_STOP) begin
      motor_set_two <= set_level;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ramp_two <= 1'b0;
    end else begin
      ramp_two <= two_level;
    end
  end

  assign interval_up   = ramp_two ? accel2_reg : accel1_reg;
  assign interval_down = ramp_two ? decel2_reg : decel1_reg;

  // sequencing
  assign delay_done = delay_cnt_reg >= delay_reg;

  always_comb begin
    state_next   = state_reg;
    restart_load = 1'b0;
    case (state_reg)
      drive_pkg::ST_STOP: begin
        if (run_level && !coast_level) begin
          state_next   = drive_pkg::ST_RUN;
          restart_load = 1'b1;
        end
      end
      drive_pkg::ST_RUN: begin
        if (coast_level) begin
          state_next = drive_pkg::ST_COAST;
        end else if (!run_level && ramp_freq == '0) begin
          state_next = drive_pkg::ST_STOP;
        end
      end
      drive_pkg::ST_COAST: begin
        if (!coast_level && !run_level) begin
          state_next = drive_pkg::ST_STOP;
        end else if (!coast_level && delay_reg == 16'h0000) begin
          state_next   = drive_pkg::ST_RUN;
          restart_load = 1'b1;
        end else if (!coast_level) begin
          state_next = drive_pkg::ST_WAIT;
        end
      end
      drive_pkg::ST_WAIT: begin
        if (coast_level) begin
          state_next = drive_pkg::ST_COAST;
        end else if (!run_level) begin
          state_next = drive_pkg::ST_STOP;
        end else if (delay_done) begin
          state_next   = drive_pkg::ST_RUN;
          restart_load = 1'b1;
        end
      end
      default: begin
        state_next = drive_pkg::ST_STOP;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= drive_pkg::ST_STOP;
    end else begin
      state_reg <= state_next;
    end
  end

  // delay counted in ticks; a fresh wait always starts from zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tick_cnt_reg  <= '0;
      delay_cnt_reg <= 16'h0000;
    end else if (state_reg != drive_pkg::ST_WAIT) begin
      tick_cnt_reg  <= '0;
      delay_cnt_reg <= 16'h0000;
    end else if (tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYCLES - 1)) begin
      tick_cnt_reg  <= '0;
      delay_cnt_reg <= delay_cnt_reg + 16'h0001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      output_enable <= 1'b0;
    end else begin
      output_enable <= (state_next == drive_pkg::ST_RUN) && !coast_level;
    end
  end

  assign load_value  = (state_reg != drive_pkg::ST_STOP && restart_sel)
                       ? motor_speed : '0;
  assign ramp_target = run_level ? target_reg : '0;

  ramp_gen #(
    .FREQ_W        (FW)
  ) u_ramp_gen (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .hold          (state_reg != drive_pkg::ST_RUN),
    .load          (restart_load),
    .load_value    (load_value),
    .target        (ramp_target),
    .interval_up   (interval_up),
    .interval_down (interval_down),
    .freq          (ramp_freq)
  );

  assign freq_out = ramp_freq;

  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence coast_release_s;
    state_reg == drive_pkg::ST_COAST && !coast_level;
  endsequence

  set_follow_a: assert property (
    (state_reg == drive_pkg::ST_STOP) |=> motor_set_two == $past(set_level))
    else $error("motor set did not follow terminal while stopped");

  set_defer_a: assert property (
    (state_reg != drive_pkg::ST_STOP) |=> $stable(motor_set_two))
    else $error("motor set changed while running");

  ramp_select_a: assert property (
    $rose(two_level) |=> ramp_two ##0 interval_up == accel2_reg)
    else $error("second ramp pair not taken");

  coast_off_a: assert property (
    coast_level |=> !output_enable)
    else $error("output enabled during coast");

  no_run_stop_a: assert property (
    coast_release_s and !run_level |=> state_reg == drive_pkg::ST_STOP)
    else $error("resumed without run command");

  zero_delay_a: assert property (
    coast_release_s and run_level and delay_reg == 16'h0000
    |=> state_reg == drive_pkg::ST_RUN && output_enable)
    else $error("zero delay did not resume at once");

  wait_off_a: assert property (
    (state_reg == drive_pkg::ST_WAIT && !delay_done) |=> !output_enable)
    else $error("output enabled before restart delay");

  restart_zero_a: assert property (
    (restart_load && !restart_sel) |=> ramp_freq == '0)
    else $error("restart did not begin at zero");

  restart_speed_a: assert property (
    (restart_load && restart_sel && state_reg != drive_pkg::ST_STOP)
    |=> ramp_freq == $past(motor_speed))
    else $error("restart did not begin at motor speed");

  coast_level_a: assert property (
    (term_sync_out == '0 && polarity_reg == '1) |-> coast_level ==
      (assign_reg[4:0] == drive_pkg::FN_COAST ||
       assign_reg[9:5] == drive_pkg::FN_COAST ||
       assign_reg[14:10] == drive_pkg::FN_COAST ||
       assign_reg[19:15] == drive_pkg::FN_COAST ||
       assign_reg[24:20] == drive_pkg::FN_COAST))
    else $error("inverted coast terminal not active when open");

endmodule

// ---- terminal_bank.sv ----
`timescale 1ns/1ps
module terminal_bank (
  input  wire logic        core_clk,
  input  wire logic [4:0]  level_req,
  input  wire logic [15:0] speed_req,
  output logic      [4:0]  term_in,
  output logic      [15:0] motor_speed
);
  // switches settle one edge after the request, like a real contact
  initial begin
    term_in     = 5'h00;
    motor_speed = 16'h0000;
  end
  always @(posedge core_clk) begin
    term_in     <= level_req;
    motor_speed <= speed_req;
  end
endmodule

// ---- drive_input_function_selector_tb.sv ----
`timescale 1ns/1ps
module drive_input_function_selector_tb;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic [4:0]  level_req = 5'h00;
  logic [15:0] speed_req = 16'h0000;
  logic [4:0]  term_in;
  logic [15:0] motor_speed;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, output_enable, motor_set_two, ramp_two;
  logic [15:0] freq_out;
  int          mismatches = 0;
  int          tests_run = 0;

  always #10 core_clk = ~core_clk;

  terminal_bank i_bank (.core_clk(core_clk), .level_req(level_req),
    .speed_req(speed_req), .term_in(term_in), .motor_speed(motor_speed));

  // short tick keeps restart delays to a few cycles
  drive_input_function_selector #(.TICK_CYCLES(4)) i_dut (
    .core_clk(core_clk), .reset_n(reset_n), .term_in(term_in),
    .motor_speed(motor_speed), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .output_enable(output_enable), .motor_set_two(motor_set_two),
    .ramp_two(ramp_two), .freq_out(freq_out));

  task test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task check(input string name, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // classic cycle: hold until ack is sampled, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; dat <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(name, e, q);
  endtask

  task set_terms(input logic [4:0] v);
    @(posedge core_clk);
    level_req <= v;
  endtask

  // bounded wait on one output, sampled mid-cycle
  task wait_for(input int which, input logic [15:0] v, input int lim);
    logic [15:0] s;
    for (int n = 0; n <= lim; n++) begin
      @(negedge core_clk);
      s = (which == 0) ? {15'h0, output_enable} :
          (which == 1) ? {15'h0, motor_set_two} : freq_out;
      if (s === v) return;
    end
    check("wait_for", {16'h0, v}, {16'h0, s});
  endtask

  task idle_chk(input int n, input logic oe);
    repeat (n) @(negedge core_clk);
    check("output_enable", {31'h0, oe}, {31'h0, output_enable});
  endtask

  initial begin
    #400000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check("outputs", 32'h0, {output_enable, motor_set_two, ramp_two,
                             freq_out});
    rd_chk("assign", drive_pkg::OFF_ASSIGN, {7'h0, drive_pkg::ASSIGN_RST});
    rd_chk("accel1", drive_pkg::OFF_ACCEL1, {16'h0, drive_pkg::RAMP_RST});
    rd_chk("delay", drive_pkg::OFF_DELAY, 32'h0);
    wb(1'b1, 8'h3c, 32'hffff);
    rd_chk("unmapped", 8'h3c, 32'h0);
    // slow ramp one, fast ramp two
    wb(1'b1, drive_pkg::OFF_ACCEL1, 32'h40);
    wb(1'b1, drive_pkg::OFF_DECEL1, 32'h0);
    wb(1'b1, drive_pkg::OFF_ACCEL2, 32'h0);
    wb(1'b1, drive_pkg::OFF_DECEL2, 32'h0);
    wb(1'b1, drive_pkg::OFF_TARGET, 32'h10);
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h1);
    wait_for(0, 16'h1, 5);
    repeat (10) @(posedge core_clk);
    set_terms(5'h02); // switch rate mid ramp
    wait_for(2, 16'h10, 60); // reach target at rate two
    check("ramp_two", 32'h1, {31'h0, ramp_two});
    rd_chk("status_two", drive_pkg::OFF_STATUS, 32'h16);
    set_terms(5'h03); // select set two while running
    idle_chk(10, 1'b1);
    check("set_two", 32'h0, {31'h0, motor_set_two});
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h0);
    wait_for(2, 16'h0, 60);
    wait_for(1, 16'h1, 10); // takes effect once stopped
    set_terms(5'h02);
    wait_for(1, 16'h0, 10); // back to main set
    // coast with delay two ticks, restart from zero
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h1);
    wait_for(2, 16'h10, 60);
    set_terms(5'h06);
    wait_for(0, 16'h0, 4); // output off within sync time
    wb(1'b1, drive_pkg::OFF_DELAY, 32'h2);
    set_terms(5'h02);
    idle_chk(6, 1'b0); // still waiting
    wait_for(0, 16'h1, 12); // resumes after delay
    check("freq_zero", 32'h0, {16'h0, freq_out});
    // restart from motor speed, no delay
    wb(1'b1, drive_pkg::OFF_DELAY, 32'h0);
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h3);
    speed_req <= 16'h0008;
    wait_for(2, 16'h10, 60);
    set_terms(5'h06);
    wait_for(0, 16'h0, 4);
    set_terms(5'h02);
    wait_for(0, 16'h1, 5); // zero delay skips waiting
    check("freq_speed", 32'h8, {16'h0, freq_out});
    // release without run keeps output off
    set_terms(5'h06);
    wait_for(0, 16'h0, 4);
    rd_chk("status_coast", drive_pkg::OFF_STATUS, 32'h3a);
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h0);
    set_terms(5'h02);
    idle_chk(10, 1'b0);
    // coast moved to terminal five, normally closed
    wb(1'b1, drive_pkg::OFF_ASSIGN, {7'h0, drive_pkg::FN_COAST,
      drive_pkg::FN_NONE, drive_pkg::FN_NONE, drive_pkg::FN_RAMP_TWO,
      drive_pkg::FN_MOTOR_SET});
    wb(1'b1, drive_pkg::OFF_POLARITY, 32'h10);
    set_terms(5'h00);
    wb(1'b1, drive_pkg::OFF_CTRL, 32'h1);
    idle_chk(10, 1'b0); // open contact holds coast
    set_terms(5'h10);
    wait_for(0, 16'h1, 8); // terminal five releases coast
    test_done();
  end
endmodule
